// ==== logic/robot_io_defines.svh ====
// Constants for the dedicated remote-control input/output block.
`ifndef ROBOT_IO_DEFINES_SVH
`define ROBOT_IO_DEFINES_SVH
`define RIO_IDX_W 5
`define RIO_STOP_IDX 5'h00
`define RIO_CNT_W 8
`define RIO_CLK_PERIOD_NS 10
`define RIO_POWERUP_TIME_NS 1000
`define RIO_POWERUP_CYCLES ((`RIO_POWERUP_TIME_NS + `RIO_CLK_PERIOD_NS - 1) / `RIO_CLK_PERIOD_NS)
`define RIO_NUM_STATUS 15
`define RIO_E_START 0
`define RIO_E_PROGRESET 1
`define RIO_E_ERRCLEAR 2
`define RIO_E_CYCLE 3
`define RIO_E_SERVOON 4
`define RIO_E_LOCK 5
`define RIO_E_EVASION 6
`define RIO_E_NUM 7
`endif

// ==== logic/robot_io_pkg.sv ====
// Types shared by the dedicated remote-control input/output block.
`include "robot_io_defines.svh"
package robot_io_pkg;
	typedef logic [`RIO_IDX_W-1:0] sigIdx_t;
	typedef enum logic [1:0] {MODE_TEACH, MODE_AUTO, MODE_REMOTE} mode_t;
	typedef enum logic [1:0] {SLOT_IDLE, SLOT_RUN, SLOT_CYCLE, SLOT_WAIT} slot_t;
	typedef struct packed {
		sigIdx_t secondStop;
		sigIdx_t automaticEnable;
		sigIdx_t servoDisable;
		sigIdx_t operationRights;
		sigIdx_t start;
		sigIdx_t programReset;
		sigIdx_t errorClear;
		sigIdx_t cycleStop;
		sigIdx_t servoPowerOn;
		sigIdx_t machineLock;
		sigIdx_t evasionPointReturn;
	} inMap_t;
	typedef logic [`RIO_NUM_STATUS-1:0][`RIO_IDX_W-1:0] outMap_t;
	typedef struct packed {
		logic teachingModeOut;
		logic automaticModeOut;
		logic remoteModeOut;
		logic powerOnCompleteOut;
		logic automaticEnableOut;
		logic operatingOut;
		logic waitOut;
		logic programSelectOut;
		logic errorOut;
		logic cycleStopOut;
		logic servoDisableOut;
		logic servoOnOut;
		logic operationRightsOut;
		logic machineLockOut;
		logic evasionReturnOut;
	} status_t;
endpackage

// ==== logic/edge_rise.sv ====
// Rising-edge detector for event-type command inputs.
`timescale 1ns/10ps
module edge_rise #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Levels in, one-cycle pulses out
	input wire logic [W-1:0] level,
	output logic [W-1:0] rise
);
	typedef struct packed {
		logic [W-1:0] prev;
	} edgeState_t;
	edgeState_t st_ff;
	edgeState_t nxt_st;

	if (W < 1)
	begin : g_chk
		$error("edge_rise: W must be at least 1");
	end

	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.prev = level;
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	// An input already active when reset ends reads as a fresh edge once.
	assign rise = level & ~st_ff.prev;

	property p_riseOnly;
		@(posedge ref_clk) disable iff (!arst_n)
		// The level before reset ended is not a valid history, so the first cycle after it is left out.
		(|rise) && $past(arst_n) |-> ((rise & $past(level)) == '0);
	endproperty
	a_riseOnly: assert property (p_riseOnly) else $error("edge pulse without a low-to-high change");
endmodule

// ==== logic/robot_dedicated_io_control.sv ====
// Dedicated remote-control input/output logic of the robot controller.
`timescale 1ns/10ps
`include "robot_io_defines.svh"
module robot_dedicated_io_control #(
	parameter int NUM_IN = 32,
	parameter int NUM_OUT = 32,
	parameter int NUM_MECH = 1,
	parameter int POWERUP_CYCLES = `RIO_POWERUP_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic arst_n,
	// Signal number assignment
	input wire robot_io_pkg::inMap_t inMap,
	input wire robot_io_pkg::outMap_t outMap,
	// Controller core
	input wire robot_io_pkg::mode_t modeSel,
	input wire logic progDone,
	input wire logic errEvent,
	input wire logic evasionDone,
	input wire logic [NUM_MECH-1:0] servoTrip,
	// External dedicated signals
	input wire logic [NUM_IN-1:0] extIn,
	output logic [NUM_OUT-1:0] extOut,
	// Named status
	output robot_io_pkg::status_t status
);
	import robot_io_pkg::*;

	typedef struct packed {
		logic [`RIO_CNT_W-1:0] upCnt;
		logic ready;
		slot_t slot;
		logic error;
		logic [NUM_MECH-1:0] servo;
		logic lock;
		logic evasion;
		status_t stat;
		logic [NUM_OUT-1:0] outVec;
	} state_t;

	state_t st_ff;
	state_t nxt_st;
	logic [`RIO_E_NUM-1:0] evIn;
	logic [`RIO_E_NUM-1:0] evRise;
	logic stopAny;
	logic autoEn;
	logic servoDis;
	logic rights;
	logic cmdOk;
	logic startOk;

	if (NUM_IN < 1 || NUM_IN > (1 << `RIO_IDX_W) || NUM_OUT < 1 || NUM_OUT > (1 << `RIO_IDX_W))
	begin : g_chkWidth
		$error("signal counts do not fit the signal number width");
	end
	if (NUM_MECH < 1)
	begin : g_chkMech
		$error("at least one mechanism is needed");
	end
	if (POWERUP_CYCLES < 1 || POWERUP_CYCLES >= (1 << `RIO_CNT_W))
	begin : g_chkUp
		$error("power-up count does not fit its counter");
	end

	// Unassigned numbers beyond the input count read as inactive.
	function automatic logic pick(input logic [NUM_IN-1:0] v, input sigIdx_t i);
		pick = (int'(i) < NUM_IN) ? v[i] : 1'b0;
	endfunction

	function automatic logic [NUM_OUT-1:0] mapOut(input outMap_t m, input logic [`RIO_NUM_STATUS-1:0] s);
		mapOut = '0;
		for (int k = 0; k < `RIO_NUM_STATUS; k++)
		begin
			if (s[k] && int'(m[k]) < NUM_OUT)
				mapOut[m[k]] = 1'b1;
		end
	endfunction

	always_comb
	begin
		evIn = '0;
		evIn[`RIO_E_START] = pick(extIn, inMap.start);
		evIn[`RIO_E_PROGRESET] = pick(extIn, inMap.programReset);
		evIn[`RIO_E_ERRCLEAR] = pick(extIn, inMap.errorClear);
		evIn[`RIO_E_CYCLE] = pick(extIn, inMap.cycleStop);
		evIn[`RIO_E_SERVOON] = pick(extIn, inMap.servoPowerOn);
		evIn[`RIO_E_LOCK] = pick(extIn, inMap.machineLock);
		evIn[`RIO_E_EVASION] = pick(extIn, inMap.evasionPointReturn);
	end

	// Edges are taken after mapping, so changing a number while its input is high looks like an edge.
	edge_rise #(
		.W(`RIO_E_NUM)
	) u_edge (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.level(evIn),
		.rise(evRise)
	);

	// The primary stop cannot be moved away from input number 0.
	assign stopAny = extIn[`RIO_STOP_IDX] | pick(extIn, inMap.secondStop);
	assign autoEn = st_ff.ready & pick(extIn, inMap.automaticEnable);
	assign servoDis = pick(extIn, inMap.servoDisable);
	assign rights = st_ff.ready & pick(extIn, inMap.operationRights);
	assign cmdOk = rights;
	assign startOk = evRise[`RIO_E_START] & cmdOk & autoEn & (modeSel == MODE_REMOTE) & ~stopAny & ~st_ff.error;

	always_comb
	begin
		nxt_st = st_ff;
		if (!st_ff.ready)
		begin
			nxt_st.upCnt = st_ff.upCnt + 1'b1;
			nxt_st.ready = (st_ff.upCnt == `RIO_CNT_W'(POWERUP_CYCLES - 1));
		end
		case (st_ff.slot)
			SLOT_IDLE:
			begin
				if (startOk)
					nxt_st.slot = SLOT_RUN;
			end
			SLOT_RUN:
			begin
				if (stopAny)
					nxt_st.slot = SLOT_WAIT;
				else if (st_ff.error || progDone)
					nxt_st.slot = SLOT_IDLE;
				else if (evRise[`RIO_E_CYCLE] && cmdOk)
					nxt_st.slot = SLOT_CYCLE;
			end
			SLOT_CYCLE:
			begin
				if (stopAny)
					nxt_st.slot = SLOT_WAIT;
				else if (st_ff.error || progDone)
					nxt_st.slot = SLOT_IDLE;
			end
			SLOT_WAIT:
			begin
				if (evRise[`RIO_E_PROGRESET] && cmdOk)
					nxt_st.slot = SLOT_IDLE;
				else if (startOk)
					nxt_st.slot = SLOT_RUN;
			end
			default:
			begin
				nxt_st.slot = SLOT_IDLE;
			end
		endcase
		// A new error in the clearing cycle survives the clear.
		nxt_st.error = errEvent | (st_ff.error & ~(evRise[`RIO_E_ERRCLEAR] & cmdOk));
		if (servoDis)
			nxt_st.servo = '0;
		else if (evRise[`RIO_E_SERVOON] && cmdOk)
			nxt_st.servo = '1;
		nxt_st.servo = nxt_st.servo & ~servoTrip;
		// The lock only changes while no program runs.
		if (evRise[`RIO_E_LOCK] && cmdOk && st_ff.slot != SLOT_RUN && st_ff.slot != SLOT_CYCLE)
			nxt_st.lock = ~st_ff.lock;
		if (evasionDone || stopAny || servoDis || st_ff.error)
			nxt_st.evasion = 1'b0;
		else if (evRise[`RIO_E_EVASION] && cmdOk && (|st_ff.servo) && st_ff.slot != SLOT_RUN
			&& st_ff.slot != SLOT_CYCLE)
			nxt_st.evasion = 1'b1;
		nxt_st.stat.teachingModeOut = (modeSel == MODE_TEACH);
		nxt_st.stat.automaticModeOut = (modeSel != MODE_TEACH);
		nxt_st.stat.remoteModeOut = (modeSel == MODE_REMOTE);
		nxt_st.stat.powerOnCompleteOut = nxt_st.ready;
		nxt_st.stat.automaticEnableOut = autoEn;
		nxt_st.stat.operatingOut = (nxt_st.slot == SLOT_RUN) || (nxt_st.slot == SLOT_CYCLE);
		nxt_st.stat.waitOut = (nxt_st.slot == SLOT_WAIT);
		nxt_st.stat.programSelectOut = (nxt_st.slot == SLOT_IDLE);
		nxt_st.stat.errorOut = nxt_st.error;
		nxt_st.stat.cycleStopOut = (nxt_st.slot == SLOT_CYCLE);
		nxt_st.stat.servoDisableOut = servoDis;
		nxt_st.stat.servoOnOut = |nxt_st.servo;
		nxt_st.stat.operationRightsOut = rights;
		nxt_st.stat.machineLockOut = nxt_st.lock;
		nxt_st.stat.evasionReturnOut = nxt_st.evasion;
		nxt_st.outVec = mapOut(outMap, nxt_st.stat);
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign status = st_ff.stat;
	assign extOut = st_ff.outVec;

	property p_teach;
		@(posedge ref_clk) disable iff (!arst_n)
		(modeSel == MODE_TEACH) |=> status.teachingModeOut && !status.automaticModeOut;
	endproperty
	a_teach: assert property (p_teach) else $error("teaching mode not reported");

	property p_auto;
		@(posedge ref_clk) disable iff (!arst_n)
		(modeSel == MODE_AUTO) |=> status.automaticModeOut && !status.remoteModeOut;
	endproperty
	a_auto: assert property (p_auto) else $error("automatic mode not reported");

	property p_remote;
		@(posedge ref_clk) disable iff (!arst_n)
		(modeSel == MODE_REMOTE) |=> status.remoteModeOut;
	endproperty
	a_remote: assert property (p_remote) else $error("remote mode not reported");

	property p_notReady;
		@(posedge ref_clk) disable iff (!arst_n)
		!st_ff.ready |-> !status.powerOnCompleteOut && !status.operatingOut && !status.operationRightsOut;
	endproperty
	a_notReady: assert property (p_notReady) else $error("activity before power-on complete");

	property p_autoEn;
		@(posedge ref_clk) disable iff (!arst_n)
		st_ff.ready && pick(extIn, inMap.automaticEnable) |=> status.automaticEnableOut;
	endproperty
	a_autoEn: assert property (p_autoEn) else $error("automatic enable not reflected");

	sequence s_startReq;
		startOk && (st_ff.slot == SLOT_IDLE);
	endsequence
	property p_start;
		@(posedge ref_clk) disable iff (!arst_n)
		s_startReq |=> status.operatingOut && !status.programSelectOut;
	endproperty
	a_start: assert property (p_start) else $error("start did not run the slot");

	property p_stop;
		@(posedge ref_clk) disable iff (!arst_n)
		extIn[`RIO_STOP_IDX] && status.operatingOut |=> status.waitOut && !status.operatingOut;
	endproperty
	a_stop: assert property (p_stop) else $error("stop on input 0 did not pause");

	property p_second_stop;
		@(posedge ref_clk) disable iff (!arst_n)
		pick(extIn, inMap.secondStop) && status.operatingOut |=> status.waitOut;
	endproperty
	a_second_stop: assert property (p_second_stop) else $error("second stop did not pause");

	property p_progReset;
		@(posedge ref_clk) disable iff (!arst_n)
		status.waitOut && evRise[`RIO_E_PROGRESET] && cmdOk |=> !status.waitOut && status.programSelectOut;
	endproperty
	a_progReset: assert property (p_progReset) else $error("program reset did not clear wait");

	property p_error;
		@(posedge ref_clk) disable iff (!arst_n)
		errEvent |=> status.errorOut;
	endproperty
	a_error: assert property (p_error) else $error("error event lost");

	sequence s_cycleReq;
		(st_ff.slot == SLOT_RUN) && evRise[`RIO_E_CYCLE] && cmdOk && !stopAny && !st_ff.error && !progDone;
	endsequence
	property p_cycle;
		@(posedge ref_clk) disable iff (!arst_n)
		s_cycleReq |=> status.cycleStopOut ##0 status.operatingOut;
	endproperty
	a_cycle: assert property (p_cycle) else $error("cycle stop not started");

	property p_servoOff;
		@(posedge ref_clk) disable iff (!arst_n)
		servoDis |=> status.servoDisableOut && !status.servoOnOut;
	endproperty
	a_servoOff: assert property (p_servoOff) else $error("servo disable not applied");

	property p_servoOn;
		@(posedge ref_clk) disable iff (!arst_n)
		evRise[`RIO_E_SERVOON] && cmdOk && !servoDis && servoTrip == '0 |=> status.servoOnOut && (&st_ff.servo);
	endproperty
	a_servoOn: assert property (p_servoOn) else $error("servo on not applied to all");

	property p_lock;
		@(posedge ref_clk) disable iff (!arst_n)
		evRise[`RIO_E_LOCK] && cmdOk && !status.operatingOut |=> status.machineLockOut != $past(status.machineLockOut);
	endproperty
	a_lock: assert property (p_lock) else $error("machine lock did not toggle");

	property p_mapOut;
		@(posedge ref_clk) disable iff (!arst_n)
		status.evasionReturnOut && $stable(outMap) && int'(outMap[0]) < NUM_OUT |-> extOut[outMap[0]];
	endproperty
	a_mapOut: assert property (p_mapOut) else $error("status not on its output number");
endmodule

// ==== bench/plc_model.sv ====
// Far-side controller model that drives the dedicated input lines.
`timescale 1ns/10ps
module plc_model #(
	parameter int NUM_IN = 32
) (
	// Levels held by the controller
	input wire logic [NUM_IN-1:0] lvl,
	input wire logic [NUM_IN-1:0] noise,
	// One command pulse at a time
	input wire logic go,
	input wire logic [4:0] idx,
	input wire logic eager,
	input wire logic ready,
	// Dedicated input lines
	output logic [NUM_IN-1:0] extIn
);
	logic [NUM_IN-1:0] cmd;

	// Safety stops belong on the emergency stop wiring, so the stop lines driven here only pause.
	always_comb
	begin
		cmd = '0;
		// A command waits for readiness unless a test wants it refused.
		if (go && (ready || eager))
			cmd[idx] = 1'b1;
		extIn = lvl | noise | cmd;
	end
endmodule

// ==== bench/robot_dedicated_io_control_bench.sv ====
// Self-checking bench for the dedicated remote-control input/output block.
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
	$display("Error %0t: got %h expected %h", $time, g, e); end end
module robot_dedicated_io_control_bench;
	import robot_io_pkg::*;
	logic ref_clk = 1'b0;
	logic arst_n = 1'b0;
	inMap_t inMap;
	outMap_t outMap;
	mode_t modeSel = MODE_REMOTE;
	logic progDone = 1'b0;
	logic errEvent = 1'b0;
	logic evasionDone = 1'b0;
	logic [1:0] servoTrip = 2'h0;
	logic [31:0] lvl = 32'h00000014;
	logic [31:0] noise = 32'h00000000;
	logic [31:0] extIn;
	logic [31:0] extOut;
	logic go = 1'b0;
	logic eager = 1'b0;
	logic [4:0] idx = 5'h00;
	status_t status;
	status_t want;
	status_t wantQ[$];
	int miscompares = 0;
	int n_tests = 0;
	int cycles = 0;
	integer seed = 32'hC5FBC9E9;
	event smp;

	// Short power-up count keeps the run brief; two mechanisms exercise the any-servo rule.
	robot_dedicated_io_control #(.NUM_MECH(2), .POWERUP_CYCLES(3)) i_dut (.ref_clk(ref_clk), .arst_n(arst_n),
		.inMap(inMap), .outMap(outMap), .modeSel(modeSel), .progDone(progDone), .errEvent(errEvent),
		.evasionDone(evasionDone), .servoTrip(servoTrip), .extIn(extIn), .extOut(extOut), .status(status));
	plc_model i_plc (.lvl(lvl), .noise(noise), .go(go), .idx(idx), .eager(eager),
		.ready(status.powerOnCompleteOut), .extIn(extIn));

	task automatic step(input int n);
		repeat (n)
		begin
			@(negedge ref_clk);
			// Unassigned lines carry noise that the block must ignore.
			noise = $random(seed) & 32'hFFFFF000;
		end
	endtask

	task automatic ev(input logic [4:0] i);
		idx = i;
		go = 1'b1;
		step(1);
		go = 1'b0;
		step(1);
	endtask

	task automatic kick(input logic [4:0] v);
		{servoTrip, evasionDone, errEvent, progDone} = v;
		step(1);
		{servoTrip, evasionDone, errEvent, progDone} = 5'h00;
		step(1);
	endtask

	task automatic chk();
		wantQ.push_back(want);
		->smp;
	endtask

	task automatic done(input string s);
		$display("Test %s finished", s);
	endtask

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	always @(smp)
	begin
		status_t e;
		e = wantQ.pop_front();
		`CHK(status, e)
		`CHK(extOut[14:0], e)
		`CHK(extOut[31:15], 17'h00000)
	end

	initial
	begin
		forever #5 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 2000)
		begin
			miscompares++;
			$display("Error %0t: run timed out", $time);
			final_report();
		end
	end

	initial
	begin
		inMap = {5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B};
		for (int k = 0; k < 15; k++)
			outMap[k] = 5'(k);
		step(6);
		arst_n = 1'b1;
		eager = 1'b1;
		ev(5'h05);
		eager = 1'b0;
		// The start pulse came before power-on complete, so the slot must still be idle.
		want = '0;
		want.automaticModeOut = 1'b1;
		want.remoteModeOut = 1'b1;
		want.programSelectOut = 1'b1;
		chk();
		step(2);
		want.powerOnCompleteOut = 1'b1;
		want.automaticEnableOut = 1'b1;
		want.operationRightsOut = 1'b1;
		chk();
		for (int m = 0; m < 3; m++)
		begin
			modeSel = mode_t'(m);
			step(2);
			want.teachingModeOut = (m == 0);
			want.automaticModeOut = (m != 0);
			want.remoteModeOut = (m == 2);
			chk();
		end
		done("power-up and modes");
		ev(5'h05);
		want.operatingOut = 1'b1;
		want.programSelectOut = 1'b0;
		chk();
		lvl[0] = 1'b1;
		step(2);
		want.operatingOut = 1'b0;
		want.waitOut = 1'b1;
		chk();
		lvl[0] = 1'b0;
		ev(5'h06);
		want.waitOut = 1'b0;
		want.programSelectOut = 1'b1;
		chk();
		ev(5'h05);
		lvl[1] = 1'b1;
		step(2);
		want.waitOut = 1'b1;
		want.programSelectOut = 1'b0;
		chk();
		lvl[1] = 1'b0;
		step(1);
		ev(5'h05);
		want.waitOut = 1'b0;
		want.operatingOut = 1'b1;
		chk();
		done("start and stops");
		ev(5'h08);
		want.cycleStopOut = 1'b1;
		chk();
		kick(5'h01);
		want.cycleStopOut = 1'b0;
		want.operatingOut = 1'b0;
		want.programSelectOut = 1'b1;
		chk();
		ev(5'h05);
		kick(5'h02);
		want.errorOut = 1'b1;
		chk();
		ev(5'h07);
		want.errorOut = 1'b0;
		chk();
		lvl[4] = 1'b0;
		step(2);
		ev(5'h05);
		want.operationRightsOut = 1'b0;
		chk();
		lvl[4] = 1'b1;
		step(2);
		done("cycle stop, error and rights");
		ev(5'h09);
		want.operationRightsOut = 1'b1;
		want.servoOnOut = 1'b1;
		chk();
		kick(5'h08);
		chk();
		kick(5'h10);
		want.servoOnOut = 1'b0;
		chk();
		ev(5'h09);
		lvl[3] = 1'b1;
		step(2);
		want.servoDisableOut = 1'b1;
		chk();
		lvl[3] = 1'b0;
		step(2);
		ev(5'h09);
		want.servoDisableOut = 1'b0;
		want.servoOnOut = 1'b1;
		chk();
		ev(5'h0A);
		want.machineLockOut = 1'b1;
		chk();
		ev(5'h0A);
		want.machineLockOut = 1'b0;
		chk();
		ev(5'h0B);
		want.evasionReturnOut = 1'b1;
		chk();
		kick(5'h04);
		want.evasionReturnOut = 1'b0;
		chk();
		done("servo, lock and evasion");
		step(1);
		final_report();
	end
endmodule
